// ===== rtl/uart_defines.vh
// constants shared by the serial port design files
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH

// ----------------------------------------------------------------
// serial control register field positions
// ----------------------------------------------------------------
`define CTRL_MODE_BIT 3'd7
`define CTRL_UNUSED_BIT 3'd6
`define CTRL_MCE_BIT 3'd5
`define CTRL_REN_BIT 3'd4
`define CTRL_TB8_BIT 3'd3
`define CTRL_RB8_BIT 3'd2
`define CTRL_TI_BIT 3'd1
`define CTRL_RI_BIT 3'd0
`define CTRL_RESET 8'h40

// ----------------------------------------------------------------
// frame lengths in bit times (start bit included)
// ----------------------------------------------------------------
`define FRAME_BITS_8 4'hA
`define FRAME_BITS_9 4'hB

// ----------------------------------------------------------------
// baud timer clock source selections and divide counts
// ----------------------------------------------------------------
`define CLKSEL_SYS 3'h0
`define CLKSEL_DIV4 3'h1
`define CLKSEL_DIV12 3'h2
`define CLKSEL_DIV48 3'h3
`define CLKSEL_EXT8 3'h4
`define DIV_4 6'h04
`define DIV_12 6'h0C
`define DIV_48 6'h30
`define DIV_EXT 6'h08

`endif

// ===== rtl/uart_8n1_9bit.v
// serial port with 8-bit and 9-bit frames, timer baud source and transmit fifo
//
// Operation
// - control bit 7 selects 8 or 9-bit frame
// - 8-bit frame: start, eight data LSB-first, stop
// - one data address: read receive, write transmit
// - writing data buffer starts transmission
// - transmit-done flag set at stop-bit start
// - receive only while receive enable set
// - 8-bit receive loads byte, stop, flag conditionally
// - failed conditions leave buffer, ninth bit, flag alone
// - overrun keeps first byte, drops later ones
// - 9-bit frame: start, eight data, ninth, stop
// - transmitted ninth bit from control bit 3
// - 9-bit receive stores ninth bit, ignores stop
// - 9-bit load needs flag clear, ninth if multiproc
// - interrupt when enabled on either flag set
// - 8-bit reload timer, hidden copy for receive
// - both timer overflows halved into bit rate
// - receive timer runs with timer, same reload
// - start detection forces receive timer reload
// - rate is clock over 256-reload, halved
// - five selectable baud timer clock sources
// - receive shifts next char while buffer full

`include "uart_defines.vh"

// ----------------------------------------------------------------
// small synchronous fifo between the data buffer and the transmitter
// ----------------------------------------------------------------
module uart_tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire mclk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr; // next write slot
  reg [AW-1:0] rd_ptr; // oldest word
  reg [AW:0] count; // words held
  wire push;
  wire pop;

  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointer and level bookkeeping
  always @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

  // data array has no reset, it is only read while valid
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------
// serial port top
// ----------------------------------------------------------------
module uart_8n1_9bit #(
  parameter FIFO_DEPTH = 4
) (
  input wire mclk_i,
  input wire rst_i,
  input wire ctrl_wr_i, // write strobe for control register
  input wire [7:0] ctrl_wdata_i,
  output wire [7:0] serial_ctrl_reg_o, // control register readback
  input wire data_wr_i, // write strobe for data buffer
  input wire [7:0] data_wdata_i,
  output wire data_wr_ready_o, // transmit fifo has room
  output wire [7:0] serial_data_buf_o, // receive buffer readback
  input wire timer_run_i, // baud timer enable
  input wire [7:0] baud_reload_value_i,
  input wire [2:0] clk_sel_i, // baud timer clock source
  input wire ext_osc_tick_i, // one pulse per external oscillator edge
  input wire irq_enable_i,
  output wire irq_o,
  input wire serial_in_pin_i,
  output wire serial_out_pin_o,
  output wire tx_busy_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [7:0] serial_ctrl_reg; // mode, mce, ren, tb8, rb8, ti, ri
  reg [7:0] rx_buf; // receive buffer, separate from transmit path
  reg [5:0] pre_cnt; // prescaler for the timer clock
  reg [7:0] baud_timer_low; // transmit timer
  reg [7:0] rx_timer; // hidden receive timer copy
  reg tx_half; // transmit overflow divider
  reg rx_half; // receive overflow divider
  reg [10:0] tx_shift; // remaining transmit bits, lsb next
  reg [3:0] tx_cnt; // bit times left in current frame
  reg tx_line; // registered serial output
  reg rx_active; // frame in progress
  reg [3:0] rx_idx; // sample index within frame
  reg [8:0] rx_shift; // data bits then ninth bit
  reg rx_prev; // line level one cycle ago
  reg [5:0] div_val; // selected prescale divide
  wire timer_tick;
  wire [8:0] tx_step;
  wire [8:0] rx_step;
  wire tx_bit_tick;
  wire rx_sample;
  wire start_edge;
  wire fifo_valid;
  wire fifo_pop;
  wire [7:0] fifo_data;
  wire mode9;
  wire mce;
  wire ren;
  wire ti_set;
  wire ri_set;
  wire rb8_load;
  wire rb8_val;
  wire rx_last;
  wire ninth_ok;

  assign mode9 = serial_ctrl_reg[`CTRL_MODE_BIT];
  assign mce = serial_ctrl_reg[`CTRL_MCE_BIT];
  assign ren = serial_ctrl_reg[`CTRL_REN_BIT];

  // ----------------------------------------------------------------
  // one auto-reload timer step: {overflow, next count}
  // ----------------------------------------------------------------
  function [8:0] timer_next;
    input [7:0] cnt;
    input [7:0] reload;
    begin
      if (cnt == 8'hFF) begin
        timer_next = {1'b1, reload};
      end else begin
        timer_next = {1'b0, cnt + 8'h01};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // timer clock source selection
  // ----------------------------------------------------------------
  // divide count for the selected source
  always @* begin
    case (clk_sel_i)
      `CLKSEL_DIV4: div_val = `DIV_4;
      `CLKSEL_DIV12: div_val = `DIV_12;
      `CLKSEL_DIV48: div_val = `DIV_48;
      `CLKSEL_EXT8: div_val = `DIV_EXT;
      default: div_val = 6'h01; // system clock straight through
    endcase
  end

  // prescaler; external source counts oscillator pulses, not clocks
  always @(posedge mclk_i) begin
    if (rst_i || !timer_run_i) begin
      pre_cnt <= 6'h00;
    end else if (clk_sel_i != `CLKSEL_EXT8 || ext_osc_tick_i) begin
      pre_cnt <= (pre_cnt >= div_val - 6'h01) ? 6'h00 : pre_cnt + 6'h01;
    end
  end

  // a changed selection mid-count may stretch one tick; harmless for rate
  assign timer_tick = timer_run_i && (pre_cnt >= div_val - 6'h01) &&
                      (clk_sel_i != `CLKSEL_EXT8 || ext_osc_tick_i);

  // ----------------------------------------------------------------
  // transmit and receive baud timers
  // ----------------------------------------------------------------
  assign tx_step = timer_next(baud_timer_low, baud_reload_value_i);
  assign rx_step = timer_next(rx_timer, baud_reload_value_i);
  assign start_edge = ren && !rx_active && rx_prev && !serial_in_pin_i;

  // period is 256 - reload ticks per overflow
  always @(posedge mclk_i) begin
    if (rst_i) begin
      baud_timer_low <= 8'h00;
      tx_half <= 1'b0;
    end else if (timer_tick) begin
      baud_timer_low <= tx_step[7:0];
      if (tx_step[8]) begin
        tx_half <= ~tx_half;
      end
    end
  end

  // hidden copy, realigned to each start bit
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rx_timer <= 8'h00;
      rx_half <= 1'b0;
    end else if (start_edge) begin
      rx_timer <= baud_reload_value_i;
      rx_half <= 1'b0;
    end else if (timer_tick) begin
      rx_timer <= rx_step[7:0];
      if (rx_step[8]) begin
        rx_half <= ~rx_half;
      end
    end
  end

  assign tx_bit_tick = timer_tick && tx_step[8] && tx_half;
  // first overflow after reload is half a bit in: centre of start bit
  assign rx_sample = rx_active && timer_tick && rx_step[8] && !rx_half;

  // ----------------------------------------------------------------
  // transmit fifo and shifter
  // ----------------------------------------------------------------
  uart_tx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_tx_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(data_wr_i),
    .in_ready_o(data_wr_ready_o),
    .in_data_i(data_wdata_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // a new frame may start only on a bit boundary once the stop has run
  assign fifo_pop = fifo_valid && tx_bit_tick && (tx_cnt == 4'h0);
  assign ti_set = tx_bit_tick && (tx_cnt == 4'h1);

  // frame shifter; stop bit already counted in tx_cnt
  always @(posedge mclk_i) begin
    if (rst_i) begin
      tx_shift <= 11'h7FF;
      tx_cnt <= 4'h0;
      tx_line <= 1'b1;
    end else if (fifo_pop) begin
      tx_line <= 1'b0; // start bit
      if (mode9) begin
        tx_shift <= {2'b11, serial_ctrl_reg[`CTRL_TB8_BIT], fifo_data};
        tx_cnt <= `FRAME_BITS_9 - 4'h1;
      end else begin
        tx_shift <= {3'b111, fifo_data};
        tx_cnt <= `FRAME_BITS_8 - 4'h1;
      end
    end else if (tx_bit_tick && tx_cnt != 4'h0) begin
      tx_line <= tx_shift[0]; // lsb first
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_cnt <= tx_cnt - 4'h1;
    end
  end

  assign serial_out_pin_o = tx_line;
  assign tx_busy_o = (tx_cnt != 4'h0) || fifo_valid;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign rx_last = rx_sample &&
                   (rx_idx == (mode9 ? `FRAME_BITS_9 : `FRAME_BITS_8) - 4'h1);
  // qualifying bit: stop in 8-bit mode, ninth in 9-bit mode
  assign rb8_val = mode9 ? rx_shift[8] : serial_in_pin_i;
  assign ninth_ok = !mce || rb8_val;
  // full buffer blocks the load, so the first byte survives an overrun
  assign rb8_load = rx_last && ren && !serial_ctrl_reg[`CTRL_RI_BIT] && ninth_ok;
  assign ri_set = rb8_load;

  // frame sequencer; shifting goes on whatever the buffer holds
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rx_active <= 1'b0;
      rx_idx <= 4'h0;
      rx_shift <= 9'h000;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= serial_in_pin_i;
      if (start_edge) begin
        rx_active <= 1'b1;
        rx_idx <= 4'h0;
      end else if (rx_sample) begin
        if (rx_idx == 4'h0 && serial_in_pin_i) begin
          rx_active <= 1'b0; // glitch, not a real start
        end else if (rx_last || !ren) begin
          rx_active <= 1'b0;
        end else begin
          rx_idx <= rx_idx + 4'h1;
          if (rx_idx != 4'h0 && !(mode9 && rx_idx == 4'h9)) begin
            rx_shift <= {rx_shift[8], serial_in_pin_i, rx_shift[7:1]};
          end else if (rx_idx == 4'h9) begin
            rx_shift[8] <= serial_in_pin_i;
          end
        end
      end
    end
  end

  // receive buffer loads only when the frame qualifies
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rx_buf <= 8'h00;
    end else if (rb8_load) begin
      rx_buf <= rx_shift[7:0];
    end
  end

  assign serial_data_buf_o = rx_buf;

  // ----------------------------------------------------------------
  // control register; hardware set beats a software clear
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      serial_ctrl_reg <= `CTRL_RESET;
    end else begin
      if (ctrl_wr_i) begin
        serial_ctrl_reg <= ctrl_wdata_i;
        serial_ctrl_reg[`CTRL_UNUSED_BIT] <= 1'b1;
      end
      if (ti_set) begin
        serial_ctrl_reg[`CTRL_TI_BIT] <= 1'b1;
      end
      if (ri_set) begin
        serial_ctrl_reg[`CTRL_RI_BIT] <= 1'b1;
        serial_ctrl_reg[`CTRL_RB8_BIT] <= rb8_val;
      end
    end
  end

  assign serial_ctrl_reg_o = serial_ctrl_reg;

  // flags stay set until software writes them low
  assign irq_o = irq_enable_i &&
                 (serial_ctrl_reg[`CTRL_TI_BIT] || serial_ctrl_reg[`CTRL_RI_BIT]);
endmodule

// ===== verification/uart_8n1_9bit_chk.sv
// port checker for the serial port top
module uart_8n1_9bit_chk (
  input logic mclk_i,
  input logic rst_i,
  input logic ctrl_wr_i,
  input logic [7:0] ctrl_wdata_i,
  input logic [7:0] serial_ctrl_reg_o,
  input logic data_wr_i,
  input logic data_wr_ready_o,
  input logic [7:0] serial_data_buf_o,
  input logic [7:0] baud_reload_value_i,
  input logic [2:0] clk_sel_i,
  input logic irq_enable_i,
  input logic irq_o,
  input logic serial_out_pin_o,
  input logic tx_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // bit figures below only hold at four clocks per bit
  wire fast_baud = (baud_reload_value_i == 8'hFE) && (clk_sel_i == 3'h0);
  wire ti = serial_ctrl_reg_o[1]; // transmit done
  wire ri = serial_ctrl_reg_o[0]; // receive full
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_IRQ: assert property (irq_o == (irq_enable_i && (ti || ri)))
    else $error("irq does not follow flags");
  AST_CTRL_WR: assert property (ctrl_wr_i |=>
    serial_ctrl_reg_o[7:3] == ($past(ctrl_wdata_i[7:3]) | 5'h08))
    else $error("control write not taken");
  AST_TI_HOLD: assert property (ti && !ctrl_wr_i |=> ti)
    else $error("transmit flag cleared by hardware");
  AST_RI_HOLD: assert property (ri && !ctrl_wr_i |=> ri)
    else $error("receive flag cleared by hardware");
  AST_OVERRUN: assert property (ri |=> $stable(serial_data_buf_o))
    else $error("receive buffer overwritten while full");
  AST_BUF_LOAD: assert property (!$past(rst_i) && $changed(serial_data_buf_o) |-> $rose(ri))
    else $error("receive buffer changed without flag");
  AST_IDLE: assert property (!tx_busy_o |-> serial_out_pin_o)
    else $error("transmit line not high while idle");
  AST_BIT_LEN: assert property (fast_baud && $fell(serial_out_pin_o) |->
    !serial_out_pin_o [*4])
    else $error("low bit shorter than one bit time");
  AST_TI_STOP: assert property (fast_baud && $rose(ti) && !$past(ctrl_wr_i) |->
    serial_out_pin_o [*4])
    else $error("transmit flag not at stop bit");
  AST_REN: assert property ($rose(ri) && !$past(ctrl_wr_i) |-> $past(serial_ctrl_reg_o[4]))
    else $error("receive while disabled");
  AST_WR_BUSY: assert property (data_wr_i && data_wr_ready_o |=> tx_busy_o)
    else $error("write did not start transmitter");
  // main scenarios reached
  COV_RX: cover property ($rose(ri));
  COV_TX: cover property ($rose(ti));
  COV_FULL: cover property (data_wr_i && !data_wr_ready_o);
endmodule

// ===== verification/uart_remote_model.sv
// behavioural remote serial device on the far side of the port
module uart_remote_model #(
  parameter int BIT_CLKS = 4
) (
  input wire logic mclk_i,
  input wire logic [3:0] nbits_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] rxq[$]; // frames seen on the port's transmit line
  logic [9:0] w; // frame being captured
  initial line_o = 1'b1; // idle high
  // start bit, then nb bits of f lsb first, then back to idle
  task send(input logic [9:0] f, input logic [3:0] nb);
    @(posedge mclk_i);
    #1 line_o = 1'b0; // start bit low
    for (int i = 0; i <= nb; i++) begin
      repeat (BIT_CLKS) @(posedge mclk_i);
      #1 line_o = (i == nb) ? 1'b1 : f[i]; // lsb first
    end
  endtask
  // capture frames, sampling each bit at its centre
  initial forever begin
    @(negedge line_i);
    w = '0;
    repeat (BIT_CLKS / 2) @(posedge mclk_i);
    for (int i = 0; i < nbits_i; i++) begin
      repeat (BIT_CLKS) @(posedge mclk_i);
      w[i] = line_i; // centre sample
    end
    rxq.push_back(w);
  end
endmodule

// ===== verification/uart_8n1_9bit_tb.sv
// self-checking bench for the serial port top
module uart_8n1_9bit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, rst_i = 1, ctrl_wr_i = 0, data_wr_i = 0, timer_run_i = 0;
  logic [7:0] ctrl_wdata_i = 8'h00, data_wdata_i = 8'h00;
  logic [7:0] baud_reload_value_i = 8'hFE; // four clocks a bit
  logic [2:0] clk_sel_i = 3'h0;
  logic ext_osc_tick_i = 0, irq_enable_i = 1;
  logic [3:0] nbits = 4'h9; // bits after start taken by the peer
  wire [7:0] serial_ctrl_reg_o, serial_data_buf_o;
  wire data_wr_ready_o, irq_o, serial_in_pin_i, serial_out_pin_o, tx_busy_o;
  int num_errors = 0, check_count = 0, cyc = 0, n;
  // ----------------------------------------------------------------
  // clock, design, far side
  // ----------------------------------------------------------------
  initial forever #2.5 mclk_i = ~mclk_i;
  uart_8n1_9bit i_dut (.mclk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i, .serial_ctrl_reg_o,
    .data_wr_i, .data_wdata_i, .data_wr_ready_o, .serial_data_buf_o, .timer_run_i,
    .baud_reload_value_i, .clk_sel_i, .ext_osc_tick_i, .irq_enable_i, .irq_o,
    .serial_in_pin_i, .serial_out_pin_o, .tx_busy_o);
  uart_remote_model i_peer (.mclk_i(mclk_i), .nbits_i(nbits), .line_i(serial_out_pin_o),
    .line_o(serial_in_pin_i));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr_ctrl(input logic [7:0] v);
    @(posedge mclk_i);
    #1 ctrl_wr_i = 1;
    ctrl_wdata_i = v;
    @(posedge mclk_i);
    #1 ctrl_wr_i = 0;
  endtask
  task wr_data(input logic [7:0] v);
    @(posedge mclk_i);
    #1 data_wr_i = 1;
    data_wdata_i = v;
    @(posedge mclk_i);
    #1 data_wr_i = 0;
  endtask
  // bounded wait for k frames at the peer
  task wait_rx(input int k);
    for (int i = 0; i < 4000 && i_peer.rxq.size() < k; i++) @(posedge mclk_i);
  endtask
  // peer sends a frame, then buffer and low flags are compared
  task rx_frame(input logic [9:0] w, input logic [3:0] nb, input logic [7:0] eb,
    input logic [2:0] ef);
    i_peer.send(w, nb);
    repeat (2) @(posedge mclk_i);
    #1 check("rx_buf", 12'(serial_data_buf_o), 12'(eb));
    check("rx_flags", 12'(serial_ctrl_reg_o[2:0]), 12'(ef));
  endtask
  // times one start bit in clocks for a given timer source, then restores the fast source
  task bit_len(input logic [2:0] sel, input int exp);
    int k;
    @(posedge mclk_i);
    #1 clk_sel_i = sel;
    ext_osc_tick_i = 1; // every clock counts as an oscillator pulse
    wr_data(8'h01);
    k = 0;
    @(negedge serial_out_pin_o);
    while (serial_out_pin_o === 1'b0 && k < 4000) begin
      @(posedge mclk_i);
      #1 k++;
    end
    check("bit_len", 12'(k), 12'(exp));
    while (tx_busy_o !== 1'b0) @(posedge mclk_i);
    @(posedge mclk_i);
    #1 clk_sel_i = 3'h0;
    ext_osc_tick_i = 0;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results;
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 0;
    check("ctrl_rst", 12'(serial_ctrl_reg_o), 12'h040);
    check("outs_rst", {tx_busy_o, data_wr_ready_o, irq_o, serial_out_pin_o, serial_data_buf_o},
      12'h500);
    timer_run_i = 1;
    // 8-bit transmit, fifo filled until refused
    wr_ctrl(8'h10);
    n = 0;
    @(posedge mclk_i);
    #1;
    while (data_wr_ready_o === 1'b1 && n < 8) begin
      data_wr_i = 1;
      data_wdata_i = 8'h30 + 8'(n);
      @(posedge mclk_i);
      #1 n++;
    end
    data_wdata_i = 8'hEE; // offered while full, dropped
    @(posedge mclk_i);
    #1 data_wr_i = 0;
    check("fill", 12'(n >= 4), 12'h001);
    wait_rx(n);
    repeat (60) @(posedge mclk_i);
    #1 check("count", 12'(i_peer.rxq.size()), 12'(n));
    for (int i = 0; i < n; i++) check("tx8", 12'(i_peer.rxq.pop_front()), 12'h130 + 12'(i));
    check("ti_irq", {10'h0, irq_o, serial_ctrl_reg_o[1]}, 12'h003);
    irq_enable_i = 0;
    #1 check("irq_off", 12'(irq_o), 12'h000);
    @(posedge mclk_i);
    #1 irq_enable_i = 1;
    // 9-bit transmit with both ninth values
    nbits = 4'hA;
    for (int b = 0; b < 2; b++) begin
      wr_ctrl({4'h8, b[0], 3'h0});
      wr_data(8'hA5);
      wait_rx(1);
      check("tx9", 12'(i_peer.rxq.pop_front()), {3'h1, b[0], 8'hA5});
    end
    // slower timer sources: a bit lasts 2 * (256 - reload) * divide clocks
    bit_len(3'h1, 16);
    bit_len(3'h2, 48);
    bit_len(3'h3, 192);
    bit_len(3'h4, 32);
    // receive: load, overrun, refusals, 9-bit qualify
    wr_ctrl(8'h10);
    rx_frame(10'h1A5, 4'h9, 8'hA5, 3'h5);
    rx_frame(10'h13C, 4'h9, 8'hA5, 3'h5);
    wr_ctrl(8'h30);
    rx_frame(10'h011, 4'h9, 8'hA5, 3'h0);
    wr_ctrl(8'h00);
    rx_frame(10'h122, 4'h9, 8'hA5, 3'h0);
    wr_ctrl(8'hB0);
    rx_frame(10'h244, 4'hA, 8'hA5, 3'h0);
    rx_frame(10'h155, 4'hA, 8'h55, 3'h5);
    results;
  end
endmodule
bind uart_8n1_9bit uart_8n1_9bit_chk i_chk (.mclk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i,
  .serial_ctrl_reg_o, .data_wr_i, .data_wr_ready_o, .serial_data_buf_o, .baud_reload_value_i,
  .clk_sel_i, .irq_enable_i, .irq_o, .serial_out_pin_o, .tx_busy_o);
